// File: sacp_assertions.sv
// Concurrent checks on the converter pins
`timescale 1ns/1ps
`include "sacp_params.svh"
module sacp_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic unit_sel_n,
  input wire logic conv_start_n,
  input wire logic read_n,
  input wire logic busy_n,
  input wire logic [15:0] data_out,
  input wire logic data_oe
);
  localparam logic [5:0] CONV_LEN = 6'(`SACP_CONV_CYCLES);
  localparam logic [5:0] START_LEN = 6'(`SACP_START_LOW_CYCLES);
  logic [5:0] low_cnt;
  logic [5:0] start_cnt;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) low_cnt <= 6'h00;
    else low_cnt <= busy_n ? 6'h00 : low_cnt + 6'h01;
  end
  // Saturating so a held strobe never wraps back into the narrow range
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) start_cnt <= 6'h00;
    else if (conv_start_n) start_cnt <= 6'h00;
    else if (start_cnt != 6'h3F) start_cnt <= start_cnt + 6'h01;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_conv_length: assert property ($rose(busy_n) |-> low_cnt == CONV_LEN)
    else $error("busy low span differs from 28 cycles");
  a_busy_bound: assert property (!busy_n |-> low_cnt < CONV_LEN)
    else $error("conversion overran its time");
  a_start_busy: assert property ($fell(conv_start_n) && !unit_sel_n && busy_n |-> ##[3:6] !busy_n)
    else $error("selected start edge did not begin a conversion");
  a_data_change: assert property ($changed(data_out) |-> $rose(busy_n))
    else $error("result changed other than at the end of conversion");
  a_oe_on: assert property ((!unit_sel_n && !read_n) [*6] |-> data_oe)
    else $error("drivers off while selected and read low");
  a_oe_off: assert property (read_n [*6] |-> !data_oe)
    else $error("drivers on without read strobe");
  a_start_low: assert property ($rose(conv_start_n) |-> start_cnt < START_LEN || start_cnt > CONV_LEN)
    else $error("start low time in the forbidden band");
  a_busy_gap: assert property ($rose(busy_n) |=> busy_n [*2])
    else $error("conversion restarted at once");
  c_read_low: cover property ($rose(busy_n) && !read_n);
  c_read_high: cover property ($rose(busy_n) && read_n);
  c_long_start: cover property ($rose(conv_start_n) && start_cnt > CONV_LEN);
endmodule : sacp_assertions

// File: sacp_device.sv
// Converter end: start detection, conversion timer, output latch and drivers
// Operation
// R01: Falling start edge with select low converts
// R02: Start edges ignored while converting
// R03: Busy low throughout each conversion
// R04: Host uses narrow start pulses; slow mode holds start low through the conversion
// R05: Start low under 500ns or past conversion
// R06: Select and read low keep outputs driven
// R07: Outputs float until read strobe asserted
// R08: Combined modes tie start and read
// R09: Slow memory shows previous result while converting
// R10: Host waits while busy low
// R11: New result and busy high together
// R12: ROM strobe starts conversion, returns previous
// R13: Start and read honoured only when selected
// R14: Drivers on when read and select low
// R15: Result two's complement, MSB on bit 15
// R16: Conversion done within 2.8us
// R17: Result latched at end, held till next
`timescale 1ns/1ps
`include "sacp_params.svh"
module sacp_device
  import sacp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sacp_if.device link,
  input wire logic [15:0] sample_code,
  output logic sample_take,
  output logic converting
);
  typedef enum {CV_IDLE, CV_RUN, CV_LOAD} sacp_conv_e;
  localparam int CONV_CYC = `SACP_CONV_CYCLES;
  localparam sacp_word_t RESULT_RST = `SACP_RESULT_RST;
  logic [2:0] start_sync;
  logic [2:0] sel_sync;
  logic [2:0] rd_sync;
  logic start_lvl;
  logic start_prev;
  logic sel_lvl;
  logic rd_lvl;
  logic [5:0] count;
  sacp_conv_e phase;
  sacp_word_t result;
  logic start_fall;
  logic load_now;

  // Start pin chain; only the second stage reads the first
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_sync <= 3'h7;
    end else begin
      start_sync <= {start_sync[1:0], link.conv_start_n};
    end
  end

  // Select pin chain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_sync <= 3'h7;
    end else begin
      sel_sync <= {sel_sync[1:0], link.unit_sel_n};
    end
  end

  // Read pin chain
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_sync <= 3'h7;
    end else begin
      rd_sync <= {rd_sync[1:0], link.read_n};
    end
  end

  // Second and third stages agree before a pin change counts
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_lvl <= 1'b1;
    end else if (start_sync[2] == start_sync[1]) begin
      start_lvl <= start_sync[1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_lvl <= 1'b1;
    end else if (sel_sync[2] == sel_sync[1]) begin
      sel_lvl <= sel_sync[1];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_lvl <= 1'b1;
    end else if (rd_sync[2] == rd_sync[1]) begin
      rd_lvl <= rd_sync[1];
    end
  end

  // Resets to the idle high level, so no false edge follows reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_prev <= 1'b1;
    end else begin
      start_prev <= start_lvl;
    end
  end

  // Select judged on its filtered level, same delay as the start pin
  assign start_fall = start_prev & ~start_lvl & ~sel_lvl; // see R01 see R13

  // Phase: idle, counting, then the single load cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= CV_IDLE;
    end else begin
      case (phase)
        CV_IDLE: begin
          if (start_fall) begin
            phase <= CV_RUN; // see R01
          end
        end
        CV_RUN: begin
          if (count == 6'h02) begin
            phase <= CV_LOAD;
          end
        end
        CV_LOAD: begin
          phase <= CV_IDLE;
        end
        default: begin
          phase <= CV_IDLE;
        end
      endcase
    end
  end

  // Busy counter; edges during a conversion are dropped, not queued
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= 6'h00;
    end else if (count != 6'h00) begin
      count <= count - 6'h01; // see R02 see R16
    end else if (start_fall && (phase == CV_IDLE)) begin
      count <= 6'(CONV_CYC); // see R01
    end
  end

  assign load_now = (phase == CV_LOAD);

  // Result loaded only in the last cycle, one latch per output bit
  generate
    for (genvar b = 0; b < `SACP_DATA_W; b++) begin : g_latch
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          result[b] <= RESULT_RST[b];
        end else if (load_now) begin
          result[b] <= sample_code[b]; // see R15 see R17 see R11
        end
      end
    end
  endgenerate

  assign converting = (phase != CV_IDLE);
  assign sample_take = load_now;
  // Busy rises at the same edge that the new word appears
  assign link.busy_n = ~converting; // see R03 see R11
  // Old word stays on the pins during conversion
  assign link.data_out = result; // see R09 see R12
  // Enable follows filtered levels, so it lags the read pin by four edges
  assign link.data_oe = ~sel_lvl & ~rd_lvl; // see R14 see R06 see R07 see R13
endmodule : sacp_device

// File: sacp_host.sv
// Host end: issues start pulses and reads results in the chosen mode
`timescale 1ns/1ps
`include "sacp_params.svh"
module sacp_host
  import sacp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  sacp_if.host link,
  input wire sacp_mode_e mode,
  input wire logic req,
  output logic req_ready,
  output logic word_valid,
  input wire logic word_ready,
  output sacp_word_t word
);
  typedef enum {ST_IDLE, ST_PULSE, ST_WAIT_LOW, ST_WAIT_HIGH, ST_READ} sacp_state_e;
  // Four low cycles; exactly the start low limit would not be below it
  localparam int PULSE_CYC = `SACP_START_LOW_CYCLES - 2;
  sacp_state_e state;
  logic [2:0] busy_sync;
  logic busy_lvl;
  logic busy_prev;
  logic [3:0] pulse_cnt;
  logic [1:0][15:0] buf_data;
  logic [1:0] cnt;
  logic wr_ptr;
  logic rd_ptr;
  logic push;
  logic pop;
  logic strobe_low;
  logic [15:0] pin_data;
  logic rom_grab;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_sync <= 3'h7;
      busy_lvl <= 1'b1;
      busy_prev <= 1'b1;
    end else begin
      busy_sync <= {busy_sync[1:0], link.busy_n};
      if (busy_sync[2] == busy_sync[1]) busy_lvl <= busy_sync[1];
      busy_prev <= busy_lvl;
    end
  end

  assign pin_data = link.data_oe ? link.data_out : 16'h0000;
  assign req_ready = (state == ST_IDLE) && (cnt != 2'h2);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      pulse_cnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req && req_ready) begin
            state <= ST_PULSE;
            pulse_cnt <= 4'(PULSE_CYC);
          end
        end
        ST_PULSE: begin
          // Short low pulse keeps the release edge off bit decisions
          if (pulse_cnt != 4'h0) pulse_cnt <= pulse_cnt - 4'h1; // see R04 see R05
          else state <= ST_WAIT_LOW;
        end
        ST_WAIT_LOW: begin
          if (!busy_lvl) state <= ST_WAIT_HIGH; // see R10
        end
        ST_WAIT_HIGH: begin
          if (busy_lvl && !busy_prev) state <= ST_READ; // see R06 see R11
        end
        ST_READ: begin
          // Read mode holds its strobe until the drivers are seen on
          if ((mode != SACP_MODE_READ) || link.data_oe) state <= ST_IDLE; // see R07
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Slow mode holds the combined strobe low across the wait
  assign strobe_low = (state == ST_PULSE) ||
    ((mode == SACP_MODE_SLOW) && (state == ST_WAIT_LOW || state == ST_WAIT_HIGH || state == ST_READ));
  assign link.unit_sel_n = 1'b0;
  assign link.conv_start_n = ~strobe_low; // see R08
  always_comb begin
    case (mode)
      SACP_MODE_ALWAYS: link.read_n = 1'b0; // see R06
      SACP_MODE_READ: link.read_n = ~(state == ST_READ); // see R07
      default: link.read_n = ~strobe_low; // see R08 see R12
    endcase
  end

  // Device enables its drivers four edges after the strobe falls
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) rom_grab <= 1'b0;
    else rom_grab <= (state == ST_PULSE) && (pulse_cnt == 4'h0);
  end

  // ROM mode takes the previous word just after its short strobe
  assign push = (mode == SACP_MODE_ROM) ? rom_grab :
    ((state == ST_READ) && ((mode != SACP_MODE_READ) || link.data_oe)); // see R12
  assign pop = word_valid && word_ready;
  assign word_valid = (cnt != 2'h0);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_data <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) begin
        buf_data[wr_ptr] <= pin_data; // see R12
        wr_ptr <= ~wr_ptr;
      end
      if (pop) rd_ptr <= ~rd_ptr;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) word <= 16'h0000;
    else if (pop && (cnt == 2'h2 || !push)) word <= buf_data[~rd_ptr];
    else if (!word_valid || pop) word <= push ? pin_data : buf_data[rd_ptr];
  end
endmodule : sacp_host

// File: sacp_if.sv
// Pin-level link between converter and host
`timescale 1ns/1ps
interface sacp_if;
  logic unit_sel_n;
  logic conv_start_n;
  logic read_n;
  logic busy_n;
  logic [15:0] data_out;
  logic data_oe;
  modport device (
    input unit_sel_n,
    input conv_start_n,
    input read_n,
    output busy_n,
    output data_out,
    output data_oe
  );
  modport host (
    output unit_sel_n,
    output conv_start_n,
    output read_n,
    input busy_n,
    input data_out,
    input data_oe
  );
endinterface : sacp_if

// File: sacp_params.svh
// Timing and width constants for the converter control port
`ifndef SACP_PARAMS_SVH
`define SACP_PARAMS_SVH
`define SACP_DATA_W 16
`define SACP_CLK_NS 100
`define SACP_CONV_TIME_NS 2800
`define SACP_CONV_CYCLES ((`SACP_CONV_TIME_NS) / (`SACP_CLK_NS))
`define SACP_START_LOW_TIME_NS 500
`define SACP_START_LOW_CYCLES ((`SACP_START_LOW_TIME_NS) / (`SACP_CLK_NS))
`define SACP_RESULT_RST 16'h0000
`endif

// File: sacp_pkg.sv
// Types shared by both ends of the converter control port
package sacp_pkg;
  typedef logic [15:0] sacp_word_t;
  typedef enum logic [1:0] {
    SACP_MODE_ALWAYS,
    SACP_MODE_READ,
    SACP_MODE_SLOW,
    SACP_MODE_ROM
  } sacp_mode_e;
endpackage : sacp_pkg

// File: sacp_test.sv
// Both ends joined, driven through the host's user side
`timescale 1ns/1ps
module sacp_test;
  import sacp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  sacp_mode_e mode = SACP_MODE_ALWAYS;
  logic req = 1'b0;
  logic word_ready = 1'b0;
  logic [15:0] sample_code = 16'h0000;
  logic req_ready;
  logic word_valid;
  sacp_word_t word;
  logic sample_take;
  logic converting;
  int takes = 0;
  int bad_count = 0;
  int n_tests = 0;
  sacp_mode_e modes [4] = '{SACP_MODE_READ, SACP_MODE_SLOW, SACP_MODE_ROM, SACP_MODE_ROM};
  logic [15:0] codes [4] = '{16'hA5C3, 16'h0F0F, 16'h1234, 16'hFEDC};
  // ROM mode hands back the previous result
  logic [15:0] exps [4] = '{16'hA5C3, 16'h0F0F, 16'h0F0F, 16'h1234};
  sacp_if link ();
  sacp_device sacp_device_i (.sys_clk(sys_clk), .rst(rst), .link(link), .sample_code(sample_code),
    .sample_take(sample_take), .converting(converting));
  sacp_host sacp_host_i (.sys_clk(sys_clk), .rst(rst), .link(link), .mode(mode), .req(req),
    .req_ready(req_ready), .word_valid(word_valid), .word_ready(word_ready), .word(word));
  sacp_assertions sacp_assertions_i (.sys_clk(sys_clk), .rst(rst), .unit_sel_n(link.unit_sel_n),
    .conv_start_n(link.conv_start_n), .read_n(link.read_n), .busy_n(link.busy_n),
    .data_out(link.data_out), .data_oe(link.data_oe));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sample_take === 1'b1) takes <= takes + 1;
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task timed_out(string what);
    bad_count++;
    $display("mismatch %s expected done seen timeout", what);
    close_out();
  endtask : timed_out
  // Holds the code until busy rises, the sample moment
  task convert(logic [15:0] code);
    int i;
    sample_code <= code;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge sys_clk);
    if (req_ready !== 1'b1) timed_out("req_ready");
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    for (i = 0; i < 20 && link.busy_n !== 1'b0; i++) @(posedge sys_clk);
    if (link.busy_n !== 1'b0) timed_out("busy low");
    check("converting", {15'h0000, converting}, 16'h0001);
    for (i = 0; i < 40 && link.busy_n !== 1'b1; i++) @(posedge sys_clk);
    if (link.busy_n !== 1'b1) timed_out("busy high");
  endtask : convert
  task pop(logic [15:0] exp);
    int i;
    for (i = 0; i < 20 && word_valid !== 1'b1; i++) @(posedge sys_clk);
    if (word_valid !== 1'b1) timed_out("word_valid");
    check("word", word, exp);
    word_ready <= 1'b1;
    @(posedge sys_clk);
    word_ready <= 1'b0;
    @(posedge sys_clk);
  endtask : pop
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    convert(16'h8001);
    check("data_out", link.data_out, 16'h8001);
    convert(16'h7FFF);
    repeat (8) @(posedge sys_clk);
    check("req_ready full", {15'h0000, req_ready}, 16'h0000);
    pop(16'h8001);
    pop(16'h7FFF);
    for (int k = 0; k < 4; k++) begin
      mode <= modes[k];
      convert(codes[k]);
      pop(exps[k]);
      repeat (6) @(posedge sys_clk);
      check("data_oe idle", {15'h0000, link.data_oe}, 16'h0000);
    end
    check("sample_take count", 16'(takes), 16'h0006);
    close_out();
  end
endmodule : sacp_test
